// ===== core/bbx_balance_ctrl.sv
`timescale 1ns/1ps
`include "bbx_defs.svh"
//Behaviour
// R01 - An execute command starts balancing from the latched balance command after the start delay.
// R02 - After an execute command all serial input is ignored until chip select goes high and low.
// R03 - The host pauses the whole stack by sending the execute byte with parity inverted, 10101110.
// R04 - The host resumes by sending the execute byte with correct parity, 10101111.
// R05 - A resume reuses the latched balance command without any rewrite.
// R06 - Any command byte with wrong parity stops balancing at once.
// R07 - After a resume or a new command the balancer waits the start delay before turning on.
// R08 - The status word goes out MSB first as six gate flags, three health flags, three zeros, CRC.
// R09 - Out of reset the status word reads 0x000F.
// R10 - The status check field is the inverted CRC-4 over the 12 message bits.
// R11 - The inverted check field makes an all-zero status word invalid.
// R12 - The three health flags read high only after an execute that activates a balancer.
// R13 - Bit 0 of the command byte is its parity bit.
module bbx_balance_ctrl
   import bbx_pkg::*;
#(
   parameter int START_DELAY_CYC = `BBX_START_DELAY_US * `BBX_MCLK_KHZ / 1000
) (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        chipSelectInN,
   input  wire logic        serialClockIn,
   input  wire logic        serialDataIn,
   output logic             serialDataOut,
   output logic             serialDataOutEn,
   input  wire logic [5:0]  gateDriveSense,
   input  wire logic        cellOverVoltage,
   input  wire logic        secondaryOverVoltage,
   input  wire logic        dieOverTemp,
   output logic [11:0]      balanceCtrl,
   output logic             balancerOn,
   output logic             balancePaused,
   output logic             wordDropped
);

   bbx_link_if lnk ();

   bbx_serial_link u_link (
      .serialClockIn (serialClockIn),
      .rstn          (rstn),
      .chipSelectInN (chipSelectInN),
      .serialDataIn  (serialDataIn),
      .lnk           (lnk.link)
   );

   // Link-clock outputs are flops of the link; the pins follow them directly.
   assign serialDataOut   = lnk.serialOut;
   assign serialDataOutEn = lnk.serialOutEn;

   logic [1:0]     csSync_q;
   logic [2:0]     byteSync_q;
   logic [2:0]     wordSync_q;
   logic [5:0]     gateMeta_q;
   logic [5:0]     gateSync_q;
   logic [2:0]     faultMeta_q;
   logic [2:0]     faultSync_q;
   logic           frameIdle;
   logic           byteEvt;
   logic           wordEvt;
   logic [7:0]     cmdByte;
   logic           parityOk;
   bbx_cmd_e       cmdField;
   logic           evtPause;
   logic           evtExec;

   // Two-stage synchronisers; only the second stage is read by logic.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         csSync_q <= 2'b11;
      end else begin
         csSync_q <= {csSync_q[0], chipSelectInN};
      end
   end

   // Toggle synchronisers reset to the link's toggle level, so no false event follows reset.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         byteSync_q <= 3'b000;
         wordSync_q <= 3'b000;
      end else begin
         byteSync_q <= {byteSync_q[1:0], lnk.byteTgl};
         wordSync_q <= {wordSync_q[1:0], lnk.wordTgl};
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         gateMeta_q <= 6'h00;
         gateSync_q <= 6'h00;
      end else begin
         gateMeta_q <= gateDriveSense;
         gateSync_q <= gateMeta_q;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         faultMeta_q <= 3'h0;
         faultSync_q <= 3'h0;
      end else begin
         faultMeta_q <= {cellOverVoltage, secondaryOverVoltage, dieOverTemp};
         faultSync_q <= faultMeta_q;
      end
   end

   assign frameIdle = csSync_q[1];
   assign byteEvt   = byteSync_q[2] ^ byteSync_q[1];
   assign wordEvt   = wordSync_q[2] ^ wordSync_q[1];
   assign cmdByte   = lnk.byteData;
   assign parityOk  = bbx_parity_ok(cmdByte); // R13
   assign cmdField  = bbx_cmd_e'(cmdByte[`BBX_CMD_FIELD_LSB +: 2]);
   assign evtPause  = byteEvt && !parityOk; // R06
   assign evtExec   = byteEvt && parityOk && (cmdField == BBX_CMD_EXECUTE);

   // Two-entry word buffer between the link and the holding register.
   logic [15:0]    fifoMem_q [2];
   logic           wrPtr_q;
   logic           rdPtr_q;
   logic [1:0]     fifoCnt_q;
   logic           inValid;
   logic           inReady;
   logic           outValid;
   logic           outReady;
   logic           pushEn;
   logic           popEn;
   logic [15:0]    outWord;

   assign inValid  = wordEvt;
   assign inReady  = (fifoCnt_q != 2'd2);
   assign outValid = (fifoCnt_q != 2'd0);
   assign outReady = !byteEvt;
   assign pushEn   = inValid && inReady;
   assign popEn    = outValid && outReady;
   assign outWord  = fifoMem_q[rdPtr_q];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wrPtr_q   <= 1'b0;
         rdPtr_q   <= 1'b0;
         fifoCnt_q <= 2'd0;
      end else begin
         if (pushEn) begin
            wrPtr_q <= ~wrPtr_q;
         end
         if (popEn) begin
            rdPtr_q <= ~rdPtr_q;
         end
         fifoCnt_q <= fifoCnt_q + {1'b0, pushEn} - {1'b0, popEn};
      end
   end

   always_ff @(posedge mclk) begin
      if (pushEn) begin
         fifoMem_q[wrPtr_q] <= lnk.wordData;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wordDropped <= 1'b0;
      end else if (inValid && !inReady) begin
         wordDropped <= 1'b1;
      end else if (byteEvt) begin
         wordDropped <= 1'b0;
      end
   end

   // Holding register: a word with a good check field is latched, a bad one clears it.
   logic [11:0]    hold_q;
   logic [11:0]    holdMsg;

   assign holdMsg = outWord[`BBX_WORD_W-1 -: `BBX_MSG_W];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hold_q <= `BBX_HOLD_RESET;
      end else if (popEn) begin
         if (outWord[`BBX_CRC_W-1:0] == ~bbx_crc4(holdMsg)) begin
            hold_q <= holdMsg;
         end else begin
            hold_q <= `BBX_HOLD_RESET;
         end
      end
   end

   // Balancer sequencing.
   bbx_state_e     state_q;
   logic [16:0]    delayCnt_q;
   logic           paused_q;
   logic           restart;
   logic           clearEvt;
   logic           startEvt;
   logic           stopEvt;
   logic           delayDone;

   assign restart   = paused_q || (hold_q != balanceCtrl) || (state_q == BBX_ST_OFF);
   assign clearEvt  = evtExec && (hold_q == `BBX_HOLD_RESET);
   assign startEvt  = evtExec && (hold_q != `BBX_HOLD_RESET) && restart;
   assign stopEvt   = evtPause || clearEvt;
   assign delayDone = (delayCnt_q == 17'(START_DELAY_CYC - 1));

   // An execute with an empty holding register turns balancing off.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         balanceCtrl <= `BBX_HOLD_RESET;
      end else if (clearEvt) begin
         balanceCtrl <= `BBX_HOLD_RESET;
      end else if (startEvt) begin
         balanceCtrl <= hold_q; // R01 R05
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= BBX_ST_OFF;
      end else if (stopEvt) begin
         state_q <= BBX_ST_OFF; // R06
      end else if (startEvt) begin
         state_q <= BBX_ST_DELAY; // R07
      end else begin
         unique case (state_q)
            BBX_ST_OFF: begin
               state_q <= BBX_ST_OFF;
            end
            BBX_ST_DELAY: begin
               if (delayDone) begin
                  state_q <= BBX_ST_RUN; // R07
               end
            end
            BBX_ST_RUN: begin
               state_q <= BBX_ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         delayCnt_q <= 17'h00000;
      end else if (stopEvt || startEvt || (state_q != BBX_ST_DELAY)) begin
         delayCnt_q <= 17'h00000;
      end else begin
         delayCnt_q <= delayCnt_q + 17'h00001; // R07
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         paused_q <= 1'b0;
      end else if (evtPause) begin
         paused_q <= 1'b1; // R03
      end else if (evtExec && cmdByte == `BBX_EXEC_RESUME) begin
         paused_q <= 1'b0; // R04
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         balancerOn <= 1'b0;
      end else begin
         balancerOn <= (state_q == BBX_ST_RUN) && !evtPause; // R06
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         balancePaused <= 1'b0;
      end else begin
         balancePaused <= paused_q;
      end
   end

   // Status word, frozen while a frame is open so the link reads a stable value.
   logic [11:0]    statusMsg;
   logic           executed;
   logic [15:0]    status_q;
   logic [15:0]    readback_q;

   assign executed = (state_q != BBX_ST_OFF) && (balanceCtrl != `BBX_HOLD_RESET);

   always_comb begin
      statusMsg = 12'h000;
      for (int n = 0; n < 6; n++) begin
         statusMsg[`BBX_ST_GATE_MSB - n] = executed && gateSync_q[n]
                                           && (balanceCtrl[11 - 2*n -: 2] != 2'b00); // R08
      end
      statusMsg[`BBX_ST_CELLS] = executed && !faultSync_q[2]; // R12
      statusMsg[`BBX_ST_SEC]   = executed && !faultSync_q[1]; // R12
      statusMsg[`BBX_ST_TEMP]  = executed && !faultSync_q[0]; // R12
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         status_q <= `BBX_STATUS_RESET; // R09
      end else if (frameIdle) begin
         status_q <= {statusMsg, ~bbx_crc4(statusMsg)}; // R10 R11
      end
   end

   // Readback carries a freshly computed, inverted check field.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         readback_q <= `BBX_STATUS_RESET;
      end else if (frameIdle) begin
         readback_q <= {hold_q, ~bbx_crc4(hold_q)}; // R11
      end
   end

   assign lnk.statusWord   = status_q;
   assign lnk.readbackWord = readback_q;

endmodule // bbx_balance_ctrl

// ===== core/bbx_defs.svh
`ifndef BBX_DEFS_SVH
`define BBX_DEFS_SVH

// Command byte layout and the two execute patterns.
`define BBX_CMD_BITS        8
`define BBX_CMD_FIELD_LSB   1
`define BBX_PARITY_BIT      0
`define BBX_EXEC_RESUME     8'hAF
`define BBX_EXEC_PAUSE      8'hAE

// Word layout: 12 message bits followed by a 4-bit check field.
`define BBX_WORD_W          16
`define BBX_MSG_W           12
`define BBX_CRC_W           4
`define BBX_CRC_POLY        4'h3
`define BBX_CRC_INIT        4'h0

// Status message field positions.
`define BBX_ST_GATE_MSB     11
`define BBX_ST_CELLS        5
`define BBX_ST_SEC          4
`define BBX_ST_TEMP         3

// Reset values.
`define BBX_STATUS_RESET    16'h000F
`define BBX_HOLD_RESET      12'h000

// Start delay, in microseconds, and the core clock rate in kHz.
`define BBX_START_DELAY_US  2000
`define BBX_MCLK_KHZ        25000
`define BBX_DELAY_CNT_W     17

`endif

// ===== core/bbx_link_if.sv
`timescale 1ns/1ps
interface bbx_link_if;
   logic        byteTgl;
   logic [7:0]  byteData;
   logic        wordTgl;
   logic [15:0] wordData;
   logic [15:0] statusWord;
   logic [15:0] readbackWord;
   logic        serialOut;
   logic        serialOutEn;

   modport link (
      output byteTgl, byteData, wordTgl, wordData, serialOut, serialOutEn,
      input  statusWord, readbackWord
   );
   modport core (
      input  byteTgl, byteData, wordTgl, wordData, serialOut, serialOutEn,
      output statusWord, readbackWord
   );
endinterface

// ===== core/bbx_pkg.sv
package bbx_pkg;

   typedef enum logic [1:0] {
      BBX_CMD_WRITE    = 2'b00,
      BBX_CMD_READBACK = 2'b01,
      BBX_CMD_STATUS   = 2'b10,
      BBX_CMD_EXECUTE  = 2'b11
   } bbx_cmd_e;

   typedef enum logic [2:0] {
      BBX_ST_OFF   = 3'b001,
      BBX_ST_DELAY = 3'b010,
      BBX_ST_RUN   = 3'b100
   } bbx_state_e;

   typedef logic [15:0] bbx_word_t;

   // True when the command byte holds an even number of ones.
   function automatic logic bbx_parity_ok(input logic [7:0] b);
      return ~(^b);
   endfunction

   // CRC-4 over 12 message bits, MSB first, polynomial x^4+x+1; callers invert it to form the check field.
   function automatic logic [3:0] bbx_crc4(input logic [11:0] m);
      logic [3:0] c;
      logic       fb;
      c = 4'h0;
      for (int i = 11; i >= 0; i--) begin
         fb = m[i] ^ c[3];
         c  = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
      end
      return c;
   endfunction

endpackage

// ===== core/bbx_serial_link.sv
`timescale 1ns/1ps
`include "bbx_defs.svh"
module bbx_serial_link
   import bbx_pkg::*;
(
   input wire logic serialClockIn,
   input wire logic rstn,
   input wire logic chipSelectInN,
   input wire logic serialDataIn,
   bbx_link_if.link lnk
);

   logic        frameRstN;
   logic [3:0]  bitCnt_q;
   logic        inWords_q;
   logic        discard_q;
   logic        drive_q;
   logic [7:0]  cmdByte_q;
   logic [15:0] inShift_q;
   logic [15:0] outShift_q;
   logic        byteTgl_q;
   logic [7:0]  byteData_q;
   logic        wordTgl_q;
   logic [15:0] wordData_q;
   logic [7:0]  byteNow;
   logic        byteDone;
   logic        wordDone;
   bbx_cmd_e    cmdNow;

   // The frame logic is held clear while chip select is high.
   assign frameRstN = rstn & ~chipSelectInN;
   assign byteNow   = {inShift_q[6:0], serialDataIn};
   assign cmdNow    = bbx_cmd_e'(byteNow[`BBX_CMD_FIELD_LSB +: 2]);
   assign byteDone  = !inWords_q && (bitCnt_q == 4'h7) && !discard_q;
   assign wordDone  = inWords_q && (bitCnt_q == 4'hF) && !discard_q
                      && bbx_parity_ok(cmdByte_q)
                      && (cmdByte_q[`BBX_CMD_FIELD_LSB +: 2] == BBX_CMD_WRITE);

   always_ff @(posedge serialClockIn or negedge frameRstN) begin
      if (!frameRstN) begin
         bitCnt_q   <= 4'h0;
         inWords_q  <= 1'b0;
         discard_q  <= 1'b0;
         drive_q    <= 1'b0;
         cmdByte_q  <= 8'h00;
         inShift_q  <= 16'h0000;
         outShift_q <= 16'h0000;
      end else begin
         drive_q <= 1'b1;
         if (!discard_q) begin
            inShift_q <= {inShift_q[14:0], serialDataIn};
            bitCnt_q  <= bitCnt_q + 4'h1;
            if (byteDone) begin
               bitCnt_q  <= 4'h0;
               inWords_q <= 1'b1;
               cmdByte_q <= byteNow;
               discard_q <= bbx_parity_ok(byteNow) && (cmdNow == BBX_CMD_EXECUTE); // R02
               if (bbx_parity_ok(byteNow) && cmdNow == BBX_CMD_STATUS) begin
                  outShift_q <= lnk.statusWord; // R08
               end else if (bbx_parity_ok(byteNow) && cmdNow == BBX_CMD_READBACK) begin
                  outShift_q <= lnk.readbackWord;
               end else begin
                  outShift_q <= 16'h0000;
               end
            end else begin
               outShift_q <= {outShift_q[14:0], 1'b0}; // R08
            end
         end
      end
   end

   // Events leave the frame as toggles so the core can resynchronise them.
   always_ff @(posedge serialClockIn or negedge rstn) begin
      if (!rstn) begin
         byteTgl_q  <= 1'b0;
         byteData_q <= 8'h00;
         wordTgl_q  <= 1'b0;
         wordData_q <= 16'h0000;
      end else begin
         if (byteDone) begin
            byteTgl_q  <= ~byteTgl_q;
            byteData_q <= byteNow;
         end
         if (wordDone) begin
            wordTgl_q  <= ~wordTgl_q;
            wordData_q <= {inShift_q[14:0], serialDataIn};
         end
      end
   end

   assign lnk.byteTgl     = byteTgl_q;
   assign lnk.byteData    = byteData_q;
   assign lnk.wordTgl     = wordTgl_q;
   assign lnk.wordData    = wordData_q;
   assign lnk.serialOut   = outShift_q[15];
   assign lnk.serialOutEn = drive_q;

endmodule // bbx_serial_link

// ===== dv/balance_execute_pause_status_tb.sv
`timescale 1ns/1ps
module balance_execute_pause_status_tb;
   import bbx_pkg::*;
   localparam int SDC = 20;
   logic        mclk, rstn, sck, csN, sdi, sdo, sdoEn;
   logic [5:0]  gate;
   logic        cellOv, secOv, hot, on, paused, dropped;
   logic [11:0] ctrl;
   logic [15:0] rd;
   int          nMismatch;
   int          checks;

   bbx_balance_ctrl #(.START_DELAY_CYC(SDC)) DUT (
      .mclk(mclk), .rstn(rstn), .chipSelectInN(csN), .serialClockIn(sck),
      .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOutEn(sdoEn),
      .gateDriveSense(gate), .cellOverVoltage(cellOv), .secondaryOverVoltage(secOv),
      .dieOverTemp(hot), .balanceCtrl(ctrl), .balancerOn(on), .balancePaused(paused),
      .wordDropped(dropped));
   bbx_host_model host (.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo));

   function automatic logic [15:0] word(input logic [11:0] m);
      logic [3:0] c;
      logic       fb;
      c = 4'h0;
      for (int i = 11; i >= 0; i--) begin
         fb = m[i] ^ c[3];
         c = {c[2:0], 1'b0} ^ {2'b00, fb, fb};
      end
      return {m, ~c};
   endfunction

   task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         nMismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   initial begin
      #100000;
      nMismatch++;
      print_verdict;
   end

   initial begin
      nMismatch = 0;
      checks = 0;
      rstn = 1'b0;
      gate = 6'h3F;
      cellOv = 1'b0;
      secOv = 1'b0;
      hot = 1'b0;
      tick(6);
      rstn = 1'b1;
      tick(4);
      cmp("ctrl reset", 16'h0000, {4'h0, ctrl});
      host.frame({8'hAC, 32'h0}, 24, rd);
      cmp("status reset", 16'h000F, rd);
      host.frame({8'hA9, word(12'h900), 16'h0}, 24, rd);
      host.frame({8'hAA, 32'h0}, 24, rd);
      cmp("readback", word(12'h900), rd);
      host.frame({8'hAF, 8'hAE, 24'h0}, 16, rd);
      tick(10);
      cmp("ctrl exec", 16'h0900, {4'h0, ctrl});
      cmp("paused after exec", 16'h0000, {15'h0, paused});
      cmp("on early", 16'h0000, {15'h0, on});
      tick(SDC);
      cmp("on late", 16'h0001, {15'h0, on});
      host.frame({8'hAC, 32'h0}, 24, rd);
      cmp("status run", word(12'hC38), rd);
      gate = 6'h3E;
      hot = 1'b1;
      tick(4);
      host.frame({8'hAC, 32'h0}, 24, rd);
      cmp("status hot", word(12'h430), rd);
      gate = 6'h3F;
      hot = 1'b0;
      host.frame({8'hAE, 32'h0}, 8, rd);
      tick(10);
      cmp("on paused", 16'h0000, {15'h0, on});
      cmp("paused", 16'h0001, {15'h0, paused});
      host.frame({8'hAF, 32'h0}, 8, rd);
      tick(10);
      cmp("paused resume", 16'h0000, {15'h0, paused});
      cmp("ctrl resume", 16'h0900, {4'h0, ctrl});
      cmp("on resume early", 16'h0000, {15'h0, on});
      tick(SDC);
      cmp("on resume late", 16'h0001, {15'h0, on});
      host.frame({8'hAD, 32'h0}, 8, rd);
      tick(10);
      cmp("on bad byte", 16'h0000, {15'h0, on});
      cmp("paused bad byte", 16'h0001, {15'h0, paused});
      host.frame({8'hA9, word(12'h003) ^ 16'h000F, word(12'h030)}, 40, rd);
      host.frame({8'hAA, 32'h0}, 24, rd);
      cmp("readback last", word(12'h030), rd);
      cmp("dropped", 16'h0000, {15'h0, dropped});
      host.frame({8'hA9, word(12'h030) ^ 16'h000F, 16'h0}, 24, rd);
      host.frame({8'hAA, 32'h0}, 24, rd);
      cmp("readback bad", 16'h000F, rd);
      host.frame({8'hAF, 32'h0}, 8, rd);
      tick(10);
      cmp("ctrl cleared", 16'h0000, {4'h0, ctrl});
      cmp("on cleared", 16'h0000, {15'h0, on});
      print_verdict;
   end
endmodule // balance_execute_pause_status_tb

bind bbx_balance_ctrl bbx_ctrl_checker #(.START_DELAY_CYC(START_DELAY_CYC)) uChk (
   .mclk(mclk), .rstn(rstn), .chipSelectInN(chipSelectInN), .serialClockIn(serialClockIn),
   .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
   .serialDataOutEn(serialDataOutEn), .gateDriveSense(gateDriveSense),
   .cellOverVoltage(cellOverVoltage), .secondaryOverVoltage(secondaryOverVoltage),
   .dieOverTemp(dieOverTemp), .balanceCtrl(balanceCtrl), .balancerOn(balancerOn),
   .balancePaused(balancePaused), .wordDropped(wordDropped));

// ===== dv/bbx_ctrl_assertions.sv
`timescale 1ns/1ps
module bbx_ctrl_checker
   import bbx_pkg::*;
#(
   parameter int START_DELAY_CYC = 20
) (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        chipSelectInN,
   input wire logic        serialClockIn,
   input wire logic        serialDataIn,
   input wire logic        serialDataOut,
   input wire logic        serialDataOutEn,
   input wire logic [5:0]  gateDriveSense,
   input wire logic        cellOverVoltage,
   input wire logic        secondaryOverVoltage,
   input wire logic        dieOverTemp,
   input wire logic [11:0] balanceCtrl,
   input wire logic        balancerOn,
   input wire logic        balancePaused,
   input wire logic        wordDropped
);
   logic [15:0] offCnt_q;
   logic [11:0] ctrlPrev_q;
   logic        pausePrev_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // Counts the cycles since the balancer was on, the command changed or a resume.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         offCnt_q    <= 16'h0000;
         ctrlPrev_q  <= 12'h000;
         pausePrev_q <= 1'b0;
      end else begin
         ctrlPrev_q  <= balanceCtrl;
         pausePrev_q <= balancePaused;
         if (balancerOn || (balanceCtrl != ctrlPrev_q) || (pausePrev_q && !balancePaused)) begin
            offCnt_q <= 16'h0000;
         end else if (offCnt_q != 16'hFFFF) begin
            offCnt_q <= offCnt_q + 16'h0001;
         end
      end
   end

   sequence sStaysOff;
      !balancerOn [*8];
   endsequence
   sequence sResume;
      $fell(balancePaused);
   endsequence

   chk_reset_clears: assert property ($rose(rstn) |-> balanceCtrl == 12'h000 && !balancerOn)
      else $error("outputs not clear after reset");
   chk_pause_stops: assert property ($rose(balancePaused) |-> !balancerOn)
      else $error("balancer on while pausing");
   chk_on_needs_cmd: assert property (balancerOn |-> balanceCtrl != 12'h000)
      else $error("balancer on with empty command");
   chk_start_delay: assert property ($rose(balancerOn) |-> offCnt_q >= START_DELAY_CYC - 1)
      else $error("balancer on before start delay");
   chk_new_cmd_wait: assert property ($changed(balanceCtrl) |=> sStaysOff)
      else $error("no start delay after command change");
   chk_resume_wait: assert property (sResume |-> sStaysOff)
      else $error("no start delay after resume");
   chk_oe_idle: assert property (chipSelectInN |-> !serialDataOutEn)
      else $error("output driven outside frame");
   chk_oe_rise: assert property ($rose(serialDataOutEn) |-> !chipSelectInN)
      else $error("output enabled without select");
endmodule // bbx_ctrl_checker

// ===== dv/bbx_host_model.sv
`timescale 1ns/1ps
module bbx_host_model (
   output logic      sck,
   output logic      csN,
   output logic      sdi,
   input  wire logic sdo
);
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      sdi = 1'b0;
   end

   // Sends n bits MSB first and collects the 16 bits answered after the byte.
   task automatic frame(input logic [39:0] d, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      csN = 1'b0;
      #201.7;
      for (int i = 0; i < n; i++) begin
         if (i == 24) begin
            #400;
         end
         sdi = d[39-i];
         #3 sck = 1'b1;
         #3 sck = 1'b0;
         if (i >= 7 && i < 23) begin
            rd[22-i] = sdo;
         end
      end
      #20 csN = 1'b1;
      sdi = ~sdi;
      #200;
   endtask
endmodule // bbx_host_model
